/* common/dqvref_map.svh */
// Purpose: constants of the data-lane reference level mode register
// Assumes: included by bare name from package and design modules
// Notes: every offset, field position, reset value and limit lives here
`ifndef DQVREF_MAP_SVH
`define DQVREF_MAP_SVH

// ----------------------------------------------------------------------
// command addresses
// ----------------------------------------------------------------------
`define DQVREF_MA_W 6
`define DQVREF_OP_W 8
`define DQVREF_MA_LEVEL 6'h0e
`define DQVREF_MA_SPCTL 6'h0d

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DQVREF_LEVEL_MSB 5
`define DQVREF_LEVEL_LSB 0
`define DQVREF_RANGE_BIT 6
`define DQVREF_RSVD_BIT 7
`define DQVREF_ACCESS_BIT 6
`define DQVREF_OPERATE_BIT 7

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define DQVREF_LEVEL_RST 6'h0d
`define DQVREF_RANGE_RST 1'b1
`define DQVREF_RSVD_VAL 1'b0
`define DQVREF_ACCESS_RST 1'b0
`define DQVREF_OPERATE_RST 1'b0
`define DQVREF_LEVEL_MAX 6'h32

`endif

/* common/dqvref_pkg.sv */
// Purpose: types of the data-lane reference level mode register
// Assumes: constants come from dqvref_map.svh
// Notes: one stored setting is range bit over level code
`include "dqvref_map.svh"
`default_nettype none

package dqvref_pkg;

  typedef logic [`DQVREF_LEVEL_MSB:`DQVREF_LEVEL_LSB] dqvref_level_t;

  typedef struct packed {
    logic range_sel;
    dqvref_level_t level;
  } dqvref_setting_t;

  typedef enum logic {
    DQVREF_SP0,
    DQVREF_SP1
  } dqvref_setpoint_t;

endpackage : dqvref_pkg

`default_nettype wire

/* common/dqvref_store_if.sv */
// Purpose: link between command logic and the two set point copies
// Assumes: both ends run on ref_clk
// Notes: read and operating data are registered inside the store
`default_nettype none

interface dqvref_store_if;
  import dqvref_pkg::*;

  logic wr_en;
  dqvref_setpoint_t wr_sp;
  dqvref_setting_t wr_data;
  logic rd_en;
  dqvref_setpoint_t rd_sp;
  dqvref_setting_t rd_data;
  dqvref_setpoint_t op_sp;
  dqvref_setting_t op_data;

  modport ctrl (
    output wr_en, wr_sp, wr_data, rd_en, rd_sp, op_sp,
    input rd_data, op_data
  );

  modport store (
    input wr_en, wr_sp, wr_data, rd_en, rd_sp, op_sp,
    output rd_data, op_data
  );

endinterface : dqvref_store_if

`default_nettype wire

/* core/dqvref_store.sv */
// Purpose: two physical copies of the reference setting, one per set point
// Assumes: one write per cycle, index from the access select
// Notes: read data and operating data come out of registers
`include "dqvref_map.svh"
`default_nettype none

module dqvref_store
  import dqvref_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // command side
  dqvref_store_if.store bus
);

  localparam dqvref_setting_t SETTING_RST = {`DQVREF_RANGE_RST,
                                             `DQVREF_LEVEL_RST};

  dqvref_setting_t copy [2];

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        copy[i] <= SETTING_RST;
      end
    end else if (bus.wr_en) begin
      copy[bus.wr_sp] <= bus.wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus.rd_data <= SETTING_RST;
    end else if (bus.rd_en) begin
      bus.rd_data <= copy[bus.rd_sp];
    end
  end

  // ----------------------------------------------------------------------
  // operating copy
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus.op_data <= SETTING_RST;
    end else begin
      bus.op_data <= copy[bus.op_sp];
    end
  end

endmodule : dqvref_store

`default_nettype wire

/* core/dqvref_top.sv */
// Purpose: data-lane reference level mode register with two set points
// Assumes: commands come from logic on ref_clk, one command per cycle
// Notes: read answer two edges after the command; operating level follows
//        the operate select, a change shows as a one-cycle update pulse
`include "dqvref_map.svh"
`default_nettype none

module dqvref_top
  import dqvref_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // mode register commands
  input wire logic mrw_valid,
  input wire logic mrr_valid,
  input wire logic [`DQVREF_MA_W-1:0] mr_addr,
  input wire logic [`DQVREF_OP_W-1:0] mr_op,
  // mode register read return
  output logic [`DQVREF_OP_W-1:0] mrr_data,
  output logic mrr_data_valid,
  // reference generator control
  output logic [`DQVREF_LEVEL_MSB:`DQVREF_LEVEL_LSB] vref_level,
  output logic vref_range,
  output logic vref_update,
  output logic [`DQVREF_LEVEL_MSB:`DQVREF_LEVEL_LSB] vref_step,
  output logic vref_range_changed,
  output logic vref_code_reserved,
  // set point status
  output logic access_setpoint,
  output logic active_setpoint
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // distance between two level codes, for settling time of the generator
  function automatic dqvref_level_t level_dist(
    input dqvref_level_t a,
    input dqvref_level_t b
  );
    dqvref_level_t d;
    d = '0;
    if (a >= b) begin
      d = dqvref_level_t'(a - b);
    end else begin
      d = dqvref_level_t'(b - a);
    end
    return d;
  endfunction : level_dist

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  dqvref_store_if st ();

  dqvref_setpoint_t access_sel;
  dqvref_setpoint_t operate_sel;
  dqvref_setting_t cur_setting;
  dqvref_setting_t wr_setting;
  logic hit_level;
  logic hit_spctl;
  logic wr_level;
  logic wr_spctl;
  logic rd_level;
  logic rd_pend;
  logic op_changed;

  // ----------------------------------------------------------------------
  // set point copies
  // ----------------------------------------------------------------------
  dqvref_store u_store (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(st.store)
  );

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign hit_level = (mr_addr == `DQVREF_MA_LEVEL);
  assign hit_spctl = (mr_addr == `DQVREF_MA_SPCTL);

  // a write wins if both strobes come together; the controller model does so on some level writes
  assign wr_level = mrw_valid && hit_level;
  assign wr_spctl = mrw_valid && hit_spctl;
  assign rd_level = mrr_valid && !mrw_valid && hit_level;

  // ----------------------------------------------------------------------
  // set point selects
  // ----------------------------------------------------------------------
  // only the two select bits of the control register are kept here
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_sel <= dqvref_setpoint_t'(`DQVREF_ACCESS_RST);
    end else if (wr_spctl) begin
      access_sel <= dqvref_setpoint_t'(mr_op[`DQVREF_ACCESS_BIT]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      operate_sel <= dqvref_setpoint_t'(`DQVREF_OPERATE_RST);
    end else if (wr_spctl) begin
      operate_sel <= dqvref_setpoint_t'(mr_op[`DQVREF_OPERATE_BIT]);
    end
  end

  // ----------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------
  // range and level always land together; reserved bit is dropped
  assign wr_setting.range_sel = mr_op[`DQVREF_RANGE_BIT];
  assign wr_setting.level = mr_op[`DQVREF_LEVEL_MSB:`DQVREF_LEVEL_LSB];

  assign st.wr_en = wr_level;
  assign st.wr_sp = access_sel;
  assign st.wr_data = wr_setting;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  assign st.rd_en = rd_level;
  assign st.rd_sp = access_sel;
  assign st.op_sp = operate_sel;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= rd_level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mrr_data_valid <= 1'b0;
    end else begin
      mrr_data_valid <= rd_pend;
    end
  end

  // lanes rest at zero outside a read answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mrr_data <= '0;
    end else if (rd_pend) begin
      mrr_data <= {`DQVREF_RSVD_VAL, st.rd_data};
    end else begin
      mrr_data <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // operating setting
  // ----------------------------------------------------------------------
  // only the active copy reaches the generator, the other is ignored
  assign cur_setting.range_sel = vref_range;
  assign cur_setting.level = vref_level;
  assign op_changed = (st.op_data != cur_setting);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vref_level <= `DQVREF_LEVEL_RST;
      vref_range <= `DQVREF_RANGE_RST;
    end else begin
      vref_level <= st.op_data.level;
      vref_range <= st.op_data.range_sel;
    end
  end

  // ----------------------------------------------------------------------
  // change report for the generator
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vref_update <= 1'b0;
    end else begin
      vref_update <= op_changed;
    end
  end

  // settling depends on how far the level moves
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vref_step <= '0;
    end else if (op_changed) begin
      vref_step <= level_dist(st.op_data.level, vref_level);
    end else begin
      vref_step <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vref_range_changed <= 1'b0;
    end else begin
      vref_range_changed <= (st.op_data.range_sel != vref_range);
    end
  end

  // ----------------------------------------------------------------------
  // reserved code flag
  // ----------------------------------------------------------------------
  // codes above the last step have no defined level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vref_code_reserved <= 1'b0;
    end else begin
      vref_code_reserved <= (st.op_data.level > `DQVREF_LEVEL_MAX);
    end
  end

  // ----------------------------------------------------------------------
  // set point status
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_setpoint <= `DQVREF_ACCESS_RST;
      active_setpoint <= `DQVREF_OPERATE_RST;
    end else begin
      access_setpoint <= access_sel;
      active_setpoint <= operate_sel;
    end
  end

endmodule : dqvref_top

`default_nettype wire

/* testbench/dq_vref_mode_register_bench.sv */
// Purpose: self-checking bench of the reference mode register
// Assumes: commands go through the controller model
// Notes: read answers are matched against a queue of expected bytes
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end

module dq_vref_mode_register_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mrw_valid, mrr_valid, mrr_data_valid, vref_range, vref_update;
  logic vref_range_changed, vref_code_reserved;
  logic access_setpoint, active_setpoint, acc, opr;
  logic [5:0] mr_addr, vref_level, vref_step, lv;
  logic [7:0] mr_op, mrr_data, r, exp_b;
  logic [6:0] sp [2];
  logic [7:0] exp_q [$];
  int err_count = 0;
  int checks = 0;
  int k;
  integer seed = 32'h22b8;

  always #25 ref_clk = ~ref_clk;

  dqvref_top i_dqvref_top (.ref_clk, .rst_n, .mrw_valid, .mrr_valid,
    .mr_addr, .mr_op, .mrr_data, .mrr_data_valid, .vref_level, .vref_range,
    .vref_update, .vref_step, .vref_range_changed, .vref_code_reserved,
    .access_setpoint, .active_setpoint);
  dqvref_ctrl_model i_dqvref_ctrl_model (.ref_clk, .mrw_valid, .mrr_valid,
    .mr_addr, .mr_op);

  task automatic end_sim;
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    sp = '{7'h4d, 7'h4d};
    {opr, acc} = 2'b00;
  endtask : do_reset

  task automatic rd;
    i_dqvref_ctrl_model.cmd(1'b0, 1'b1, 6'h0e, 8'h00);
    exp_q.push_back({1'b0, sp[acc]});
  endtask : rd

  // read answers, oldest note first
  always @(posedge ref_clk) begin
    if (mrr_data_valid === 1'b1) begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK(mrr_data, exp_b)
    end
  end

  initial begin
    do_reset;
    `CHK({vref_range, vref_level}, 7'h4d)
    rd;
    repeat (20) begin
      repeat (3) begin
        k = $unsigned($random(seed)) % 6;
        r = 8'($random(seed));
        lv = 6'($unsigned($random(seed)) % 51);
        case (k)
          0: begin
            i_dqvref_ctrl_model.cmd(1'b1, 1'b0, 6'h0d, r);
            {opr, acc} = r[7:6];
          end
          1, 4: begin
            i_dqvref_ctrl_model.cmd(1'b1, k == 4, 6'h0e, {r[7:6], lv});
            sp[acc] = {r[6], lv};
          end
          5: i_dqvref_ctrl_model.cmd(1'b1, 1'b0, 6'h0f, r);
          default: rd;
        endcase
      end
      i_dqvref_ctrl_model.idle(5);
      `CHK({vref_range, vref_level}, sp[opr])
      `CHK({active_setpoint, access_setpoint}, {opr, acc})
    end
    do_reset;
    `CHK({vref_range, vref_level}, 7'h4d)
    rd;
    i_dqvref_ctrl_model.idle(4);
    `CHK(exp_q.size(), 0)
    end_sim;
  end

  initial begin
    repeat (2000) @(posedge ref_clk);
    err_count++;
    end_sim;
  end
endmodule : dq_vref_mode_register_bench

`default_nettype wire

/* testbench/dqvref_asserts.sv */
// Purpose: port-level checks of the reference mode register
// Assumes: one clock, synchronous active-low reset
// Notes: bound into the top module at the foot of this file
`default_nettype none

module dqvref_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // commands
  input wire logic mrw_valid,
  input wire logic mrr_valid,
  input wire logic [5:0] mr_addr,
  input wire logic [7:0] mr_op,
  // read return
  input wire logic [7:0] mrr_data,
  input wire logic mrr_data_valid,
  // generator control
  input wire logic [5:0] vref_level,
  input wire logic vref_range,
  input wire logic vref_update,
  input wire logic [5:0] vref_step,
  input wire logic vref_range_changed,
  input wire logic vref_code_reserved,
  // set point status
  input wire logic access_setpoint,
  input wire logic active_setpoint
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_rd_lat;
    mrr_valid && !mrw_valid && mr_addr == 6'h0e |-> ##2 mrr_data_valid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_rd_cause;
    mrr_data_valid |-> $past(mrr_valid && !mrw_valid && mr_addr == 6'h0e, 2);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray read");
  property p_rd_idle;
    !mrr_data_valid |-> mrr_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle lanes");
  property p_rsvd;
    mrr_data_valid |-> !mrr_data[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_rst;
    $rose(rst_n) |-> {vref_range, vref_level} == 7'h4d
      && !access_setpoint && !active_setpoint;
  endproperty
  a_rst: assert property (p_rst) else $error("bad defaults");
  property p_sel;
    mrw_valid && mr_addr == 6'h0d
      |-> ##2 {active_setpoint, access_setpoint} == $past(mr_op[7:6], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("select not taken");
  property p_hold;
    rst_n |-> vref_update == ($changed(vref_level) || $changed(vref_range));
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_rchg;
    vref_update |-> vref_range_changed == (vref_range != $past(vref_range));
  endproperty
  a_rchg: assert property (p_rchg) else $error("range flag");
  property p_step;
    vref_step == (!vref_update ? 6'h00 : (vref_level >= $past(vref_level)
      ? vref_level - $past(vref_level) : $past(vref_level) - vref_level));
  endproperty
  a_step: assert property (p_step) else $error("step size");
  property p_resv;
    vref_code_reserved == (vref_level > 6'h32);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved flag");

  c_rd: cover property (mrr_data_valid);
  c_upd: cover property (vref_update && vref_range_changed);
  c_sw: cover property ($changed(active_setpoint));
endmodule : dqvref_asserts

bind dqvref_top dqvref_asserts i_asserts (.ref_clk, .rst_n, .mrw_valid,
  .mrr_valid, .mr_addr, .mr_op, .mrr_data, .mrr_data_valid, .vref_level,
  .vref_range, .vref_update, .vref_step, .vref_range_changed,
  .vref_code_reserved, .access_setpoint, .active_setpoint);

`default_nettype wire

/* testbench/dqvref_ctrl_model.sv */
// Purpose: controller model issuing mode register commands
// Assumes: tasks are entered right after a rising edge
// Notes: a released bus drops both strobes and shows the inverse of its last address and data
`default_nettype none

module dqvref_ctrl_model (
  // clock
  input wire logic ref_clk,
  // command bus
  output logic mrw_valid,
  output logic mrr_valid,
  output logic [5:0] mr_addr,
  output logic [7:0] mr_op
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {mrw_valid, mrr_valid, mr_addr, mr_op} = 16'h0000;

  // range and level always travel in the same byte
  task automatic cmd(input logic w, input logic r, input logic [5:0] a,
    input logic [7:0] d);
    mrw_valid <= w;
    mrr_valid <= r;
    mr_addr <= a;
    mr_op <= d;
    @(posedge ref_clk);
  endtask : cmd

  task automatic idle(input int n);
    mrw_valid <= 1'b0;
    mrr_valid <= 1'b0;
    mr_addr <= ~mr_addr;
    mr_op <= ~mr_op;
    repeat (n) @(posedge ref_clk);
  endtask : idle
endmodule : dqvref_ctrl_model

`default_nettype wire
